//--- hdl/hpus_common.sv
// Shared constants of the handset power-up sequencer and its debouncer.
// Assumes one 100 MHz clock and an asynchronous active-low reset.
`timescale 1ns/10ps

package hpus_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_US = CLK_MHZ;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  // Interval figures in their own units, typical values.
  localparam int DEBOUNCE_MS = 32;
  localparam int LDO_DELAY_STD_US = 125;
  localparam int LDO_DELAY_OPT_MS = 10;
  localparam int RESET_DELAY_MS = 20;
  localparam int HOLDUP_MS = 500;
  // Interval lengths in clock cycles.
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam int LDO_DELAY_STD_CYC = LDO_DELAY_STD_US * CYC_PER_US;
  localparam int LDO_DELAY_OPT_CYC = LDO_DELAY_OPT_MS * CYC_PER_MS;
  localparam int RESET_DELAY_CYC = RESET_DELAY_MS * CYC_PER_MS;
  localparam int HOLDUP_CYC = HOLDUP_MS * CYC_PER_MS;
  localparam int CNT_W = 32;
  // Sequencer states.
  typedef enum logic [3:0] {
    HPUS_OFF = 4'h0,
    HPUS_UP1 = 4'h1,
    HPUS_UP_D12 = 4'h2,
    HPUS_UP2 = 4'h3,
    HPUS_RST_D = 4'h4,
    HPUS_HOLDUP = 4'h5,
    HPUS_ON = 4'h6,
    HPUS_DN_RST = 4'h7,
    HPUS_DN_W2 = 4'h8,
    HPUS_DN_D1 = 4'h9
  } hpus_state_t;
endpackage

// Debounces one pin: synchronises it, then follows it only after it has
// held a new level for CYCLES consecutive clocks.
module hpus_debounce #(
  parameter int CYCLES = hpus_pkg::DEBOUNCE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic raw,
  output logic level
);
  import hpus_pkg::*;

  typedef struct packed {
    logic m;
    logic q;
    logic lvl;
    logic [CNT_W-1:0] cnt;
  } hpus_db_t;

  hpus_db_t s;
  hpus_db_t next_s;

  // A glitch shorter than the interval restarts the count from zero.
  always_comb
  begin
    next_s = s;
    next_s.m = raw;
    next_s.q = s.m;
    if (s.q == s.lvl)
    begin
      next_s.cnt = '0;
    end
    else if (s.cnt == CNT_W'(CYCLES - 1))
    begin
      next_s.lvl = s.q;
      next_s.cnt = '0;
    end
    else
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  // The accepted level comes straight from its register.
  assign level = s.lvl;
endmodule

//--- hdl/hpus_top.sv
// Power-up and power-down sequencer for two regulators and a host reset.
// Assumes comparator levels and pins are asynchronous to ref_clk and that
// the host drives power_hold_request as a plain level.
`timescale 1ns/10ps

module hpus_top #(
  parameter int DEBOUNCE_CYCLES = hpus_pkg::DEBOUNCE_CYC,
  parameter int LDO_STD_CYCLES = hpus_pkg::LDO_DELAY_STD_CYC,
  parameter int LDO_OPT_CYCLES = hpus_pkg::LDO_DELAY_OPT_CYC,
  parameter int RESET_CYCLES = hpus_pkg::RESET_DELAY_CYC,
  parameter int HOLDUP_CYCLES = hpus_pkg::HOLDUP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic power_key_in,
  input wire logic charger_detect_n,
  input wire logic power_hold_request,
  input wire logic long_delay_option,
  input wire logic [1:0] above_rise,
  input wire logic [1:0] above_fall,
  output logic first_regulator_en,
  output logic second_regulator_en,
  output logic host_reset_n,
  output logic wake_irq_n
);
  import hpus_pkg::*;

  typedef struct packed {
    hpus_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] rise_m;
    logic [1:0] rise_q;
    logic [1:0] fall_m;
    logic [1:0] fall_q;
    logic [1:0] good;
    logic hold_m;
    logic hold_q;
    logic opt_m;
    logic opt_q;
    logic key_prev;
    logic en1;
    logic en2;
    logic rst_n;
    logic irq_n;
  } hpus_top_t;

  hpus_top_t s;
  hpus_top_t next_s;
  logic key_db;
  logic chg_db;
  logic key_press;
  logic [CNT_W-1:0] ldo_last;
  logic [CNT_W-1:0] rst_last;
  logic [CNT_W-1:0] hold_last;

  // Both pins share one debouncer design; the charger pin is low active.
  hpus_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_key_db (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw(power_key_in),
    .level(key_db)
  );

  hpus_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_chg_db (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw(~charger_detect_n),
    .level(chg_db)
  );

  // Last count of each interval; the option strap picks the regulator delay.
  assign ldo_last = s.opt_q ? CNT_W'(LDO_OPT_CYCLES - 1) :
                    CNT_W'(LDO_STD_CYCLES - 1);
  assign rst_last = CNT_W'(RESET_CYCLES - 1);
  assign hold_last = CNT_W'(HOLDUP_CYCLES - 1);
  assign key_press = key_db & ~s.key_prev;

  // Sequencer and flag logic. Only a fresh key edge or a debounced charger
  // starts power-up, so a key still held after shutdown does not restart the supplies.
  always_comb
  begin
    next_s = s;
    next_s.rise_m = above_rise;
    next_s.rise_q = s.rise_m;
    next_s.fall_m = above_fall;
    next_s.fall_q = s.fall_m;
    next_s.hold_m = power_hold_request;
    next_s.hold_q = s.hold_m;
    next_s.opt_m = long_delay_option;
    next_s.opt_q = s.opt_m;
    next_s.key_prev = key_db;
    next_s.cnt = s.cnt + 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      if (s.rise_q[i])
        next_s.good[i] = 1'b1;
      else if (!s.fall_q[i])
        next_s.good[i] = 1'b0;
    end
    unique case (s.state)
      HPUS_OFF:
      begin
        next_s.cnt = '0;
        if (key_press)
        begin
          next_s.irq_n = 1'b0;
          next_s.en1 = 1'b1;
          next_s.state = HPUS_UP1;
        end
        else if (chg_db)
        begin
          next_s.en1 = 1'b1;
          next_s.state = HPUS_UP1;
        end
      end
      HPUS_UP1:
      begin
        next_s.cnt = '0;
        if (s.good[0])
          next_s.state = HPUS_UP_D12;
      end
      HPUS_UP_D12:
      begin
        if (s.cnt == ldo_last)
        begin
          next_s.en2 = 1'b1;
          next_s.state = HPUS_UP2;
        end
      end
      HPUS_UP2:
      begin
        next_s.cnt = '0;
        if (s.good[1])
          next_s.state = HPUS_RST_D;
      end
      HPUS_RST_D:
      begin
        if (s.cnt == rst_last)
        begin
          next_s.rst_n = 1'b1;
          next_s.cnt = '0;
          next_s.state = HPUS_HOLDUP;
        end
      end
      HPUS_HOLDUP, HPUS_ON:
      begin
        if (s.good != 2'b11)
        begin
          // A sagging supply resets the host at once.
          next_s.rst_n = 1'b0;
          next_s.irq_n = 1'b1;
          next_s.cnt = '0;
          next_s.state = HPUS_DN_RST;
        end
        else if (s.state == HPUS_HOLDUP && s.hold_q)
        begin
          next_s.irq_n = 1'b1;
          next_s.state = HPUS_ON;
        end
        else if (s.state == HPUS_HOLDUP && s.cnt == hold_last)
        begin
          next_s.irq_n = 1'b1;
          if (chg_db)
            next_s.state = HPUS_ON;
          else
          begin
            next_s.rst_n = 1'b0;
            next_s.cnt = '0;
            next_s.state = HPUS_DN_RST;
          end
        end
        else if (s.state == HPUS_ON && !s.hold_q && !chg_db)
        begin
          next_s.rst_n = 1'b0;
          next_s.cnt = '0;
          next_s.state = HPUS_DN_RST;
        end
      end
      HPUS_DN_RST:
      begin
        if (s.cnt == rst_last)
        begin
          next_s.en2 = 1'b0;
          next_s.state = HPUS_DN_W2;
        end
      end
      HPUS_DN_W2:
      begin
        next_s.cnt = '0;
        if (!s.good[1])
          next_s.state = HPUS_DN_D1;
      end
      HPUS_DN_D1:
      begin
        if (s.cnt == ldo_last)
        begin
          next_s.en1 = 1'b0;
          next_s.state = HPUS_OFF;
        end
      end
      default:
      begin
        next_s.state = HPUS_OFF;
      end
    endcase
  end

  // State register; the host is held in reset and wake is idle.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.irq_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Every output is a register bit, so no logic hazard reaches the pins.
  assign first_regulator_en = s.en1;
  assign second_regulator_en = s.en2;
  assign host_reset_n = s.rst_n;
  assign wake_irq_n = s.irq_n;

  // Checks of flag, sequence and shutdown behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_GOOD_SET: assert property (
    s.rise_q[0] && !s.good[0] |=> s.good[0])
    else $error("good flag did not rise");
  AST_GOOD_CLR: assert property (
    !s.fall_q[1] && !s.rise_q[1] && s.good[1] |=> !s.good[1])
    else $error("good flag did not fall");
  AST_HYST: assert property (
    s.good[0] && s.fall_q[0] |=> s.good[0])
    else $error("good flag fell above fall threshold");
  AST_EN2_ON: assert property (
    $rose(second_regulator_en) |-> $past(s.cnt) == ldo_last && s.good[0])
    else $error("second regulator enabled at wrong time");
  AST_RST_REL: assert property (
    $rose(host_reset_n) |-> $past(s.cnt) == rst_last && s.good == 2'b11)
    else $error("host reset released at wrong time");
  AST_EN2_OFF: assert property (
    $fell(second_regulator_en) |-> !host_reset_n &&
    $past(s.cnt) == rst_last)
    else $error("second regulator disabled at wrong time");
  AST_EN1_OFF: assert property (
    $fell(first_regulator_en) |-> !second_regulator_en && !s.good[1] &&
    $past(s.cnt) == ldo_last)
    else $error("first regulator disabled at wrong time");
  AST_WAKE: assert property (
    $fell(wake_irq_n) |-> $rose(first_regulator_en) && $past(key_press))
    else $error("wake line asserted without key start");
  AST_CHG: assert property (
    $rose(first_regulator_en) && wake_irq_n |-> $past(chg_db))
    else $error("silent power-up without charger");
  AST_SHUT: assert property (
    s.state == HPUS_ON && !s.hold_q && !chg_db |=> !host_reset_n)
    else $error("hold low did not reset host");
  AST_HOLD: assert property (
    s.state == HPUS_HOLDUP && s.cnt == hold_last && !s.hold_q &&
    !chg_db && s.good == 2'b11 |=> !host_reset_n && wake_irq_n)
    else $error("hold-up expiry not handled");

  COV_KEY_UP: cover property ($rose(host_reset_n) && !wake_irq_n);
  COV_HOLD_OK: cover property (s.state == HPUS_HOLDUP && s.hold_q);
  COV_FULL_OFF: cover property ($fell(first_regulator_en));
endmodule

//--- tb/hpus_host_model.sv
// Host model: drives the power hold request from the host side.
// Assumes the bench changes hold_en and lat at the falling edge.
`timescale 1ns/10ps
module hpus_host_model (
  input wire logic ref_clk,
  input wire logic host_reset_n,
  input wire logic hold_en,
  input wire logic [3:0] lat,
  output logic power_hold_request = 1'b0
);
  int cnt = 0;
  // A core in reset cannot hold power, so the request drops at once then.
  always @(negedge ref_clk)
  begin
    if (!host_reset_n || !hold_en)
    begin
      cnt <= 0;
      power_hold_request <= 1'b0;
    end
    else if (cnt >= lat)
      power_hold_request <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule

//--- tb/tb_top.sv
// Testbench of the power-up sequencer with regulator and host models.
// Assumes shortened intervals and a 100 MHz reference clock.
`timescale 1ns/10ps
module tb_top;
  import hpus_pkg::*;
  localparam int DB = 20, LS = 5, LL = 12, RS = 10, HU = 40, RD = 4;
  logic ref_clk = 0, rst_b = 0, key = 0, chg_n = 1, lng = 0;
  logic hold_en = 0;
  logic [3:0] lat = 4'h3;
  logic [1:0] kill_r = 2'h0, kill_f = 2'h0;
  logic [RD-1:0] d1 = '0, d2 = '0;
  logic hold, en1, en2, hrst_n, wake_n;
  logic [1:0] top_q;
  int fails = 0, total_checks = 0;

  // Clock at 10 ns.
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Regulators lag their enables; kill bits pull one comparator low.
  always @(negedge ref_clk)
  begin
    d1 <= {d1[RD-2:0], en1};
    d2 <= {d2[RD-2:0], en2};
  end
  assign top_q = {d2[RD-1], d1[RD-1]};

  hpus_top #(.DEBOUNCE_CYCLES(DB), .LDO_STD_CYCLES(LS),
    .LDO_OPT_CYCLES(LL), .RESET_CYCLES(RS), .HOLDUP_CYCLES(HU)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .power_key_in(key),
    .charger_detect_n(chg_n), .power_hold_request(hold),
    .long_delay_option(lng), .above_rise(top_q & ~kill_r),
    .above_fall(top_q & ~kill_f), .first_regulator_en(en1),
    .second_regulator_en(en2), .host_reset_n(hrst_n),
    .wake_irq_n(wake_n));

  hpus_host_model host (.ref_clk(ref_clk), .host_reset_n(hrst_n),
    .hold_en(hold_en), .lat(lat), .power_hold_request(hold));

  task automatic end_sim();
  begin
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  task automatic chk(input logic got, input logic exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
  begin
    total_checks++;
    if (n < lo || n > hi)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, n, lo);
    end
  end
  endtask

  function automatic logic sig(input int i);
    logic [3:0] v;
    v = {wake_n, hrst_n, en2, en1};
    return v[i];
  endfunction

  // Bounded wait for one output to reach a level, counting cycles.
  task automatic wt(input int i, input logic v, output int n);
  begin
    n = 0;
    while (sig(i) !== v)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 3000)
      begin
        fails++;
        $display("BAD t=%0t wait %h %h", $time, i, v);
        end_sim();
      end
    end
  end
  endtask

  task automatic up(input int gap, output int n);
    int m;
  begin
    wt(0, 1, n);
    wt(1, 1, m);
    chk_rng(m, gap + RD, gap + RD + 6);
    wt(2, 1, m);
    chk_rng(m, RS + RD, RS + RD + 6);
  end
  endtask

  task automatic dn(input int gap);
    int m;
  begin
    wt(2, 0, m);
    chk_rng(m, 0, 6);
    wt(1, 0, m);
    chk_rng(m, RS, RS + 2);
    wt(0, 0, m);
    chk_rng(m, gap + RD, gap + RD + 6);
  end
  endtask

  task automatic t_short();
  begin
    key = 1;
    repeat (DB / 2) @(negedge ref_clk);
    key = 0;
    repeat (DB + 10) @(negedge ref_clk);
    chk(en1, 0);
    $display("test short done");
  end
  endtask

  task automatic t_key();
    int n;
  begin
    hold_en = 1;
    key = 1;
    up(LS, n);
    chk_rng(n, DB, DB + 6);
    chk(wake_n, 0);
    key = 0;
    wt(3, 1, n);
    chk_rng(n, 1, 8);
    repeat (HU + 5) @(negedge ref_clk);
    chk(hrst_n, 1);
    hold_en = 0;
    dn(LS);
    $display("test key done");
  end
  endtask

  task automatic t_expire(input logic opt);
    int n;
  begin
    lng = opt;
    key = 1;
    up(opt ? LL : LS, n);
    key = 0;
    wt(2, 0, n);
    chk_rng(n, HU, HU + 3);
    chk(wake_n, 1);
    dn(opt ? LL : LS);
    lng = 0;
    $display("test expire done");
  end
  endtask

  task automatic t_charger();
    int n;
  begin
    chg_n = 0;
    up(LS, n);
    chk_rng(n, DB, DB + 6);
    chk(wake_n, 1);
    repeat (HU + 20) @(negedge ref_clk);
    chk(hrst_n, 1);
    chg_n = 1;
    wt(2, 0, n);
    chk_rng(n, DB, DB + 6);
    dn(LS);
    $display("test charger done");
  end
  endtask

  task automatic t_hyst();
    int n;
  begin
    hold_en = 1;
    lat = 4'h9;
    key = 1;
    up(LS, n);
    key = 0;
    wt(3, 1, n);
    kill_r = 2'h2;
    repeat (20) @(negedge ref_clk);
    chk(hrst_n, 1);
    kill_f = 2'h2;
    wt(2, 0, n);
    chk_rng(n, 1, 5);
    kill_r = 2'h0;
    kill_f = 2'h0;
    hold_en = 0;
    wt(0, 0, n);
    $display("test hyst done");
  end
  endtask

  initial
  begin
    repeat (12) @(negedge ref_clk);
    chk(hrst_n, 0);
    chk(wake_n, 1);
    rst_b = 1;
    @(negedge ref_clk);
    chk(en1, 0);
    chk(en2, 0);
    $display("test reset done");
    t_short();
    t_key();
    t_expire(0);
    t_expire(1);
    t_charger();
    t_hyst();
    end_sim();
  end
endmodule
